// ---- core/bc_seq_regs.vh ----
`ifndef BC_SEQ_REGS_VH
`define BC_SEQ_REGS_VH
`define ADDR_STACK_PTR 16'h0100
`define ADDR_MSG_COUNT 16'h0101
`define OFS_STATUS 16'h0000
`define OFS_TTAG 16'h0001
`define OFS_GAP 16'h0002
`define OFS_BLKPTR 16'h0003
`define OFS_CTRL 16'h0000
`define OFS_CMD 16'h0001
`define STACK_STEP 16'h0004
`define COUNT_LAST 16'hffff
// block status bits
`define BS_EOM 15
`define BS_SOM 14
`define BS_ERROR 12
`define BS_SS_MASKED 11
`define BS_TIMEOUT 10
`define BS_LOOP_FAIL 9
`define BS_SS 8
`define BS_WRONG_ADDR 7
`define BS_WCE 6
`define BS_SYNC 5
`define BS_INVALID 4
`define BS_FORMAT 3
`define BS_RETRY_LO 1
`define BS_RETRY_HI 2
// event codes
`define EV_NONE 4'h0
`define EV_NO_RESP 4'h1
`define EV_WCE 4'h2
`define EV_SYNC 4'h3
`define EV_INVALID 4'h4
`define EV_WRONG_ADDR 4'h5
`define EV_HANDSHAKE 4'h6
`define EV_NO_GAP 4'h7
`define EV_LOOP_FAIL 4'h8
`define EV_TX_TIMEOUT 4'h9
`define EV_STATUS_SET 4'ha
`define EV_ME_NO_DATA 4'hb
`define EV_ME_DATA 4'hc
// register map (byte addresses, byte address = 4 * word index)
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_STATE 8'h08
`define REG_IRQ 8'h0c
`define REG_CTRL_START 0
`define CFG_RETRY_EN 0
`define CFG_SS_RETRY 1
`define CFG_ENHANCED 2
`define CFG_EXPANDED 3
`define CFG_GAP_CHECK 4
`define CFG_TRANSPARENT 5
`define CFG_VALID_ME_ND 6
`define CFG_MAX_RETRY_LO 8
// interrupt bits
`define IRQ_FORMAT 0
`define IRQ_STATUS_SET 1
`define IRQ_RETRY 2
`define IRQ_HANDSHAKE 3
`define IRQ_TX_TIMEOUT 4
`define IRQ_EOF 5
// control word bits
`define CW_ME_MASK 15
`define CW_RETRY 8
`define CW_SS_MASK_LO 0
// timing
`define TX_TIMEOUT_NS 668000
`define CLK_NS 10
`define TX_TIMEOUT_CYC (`TX_TIMEOUT_NS / `CLK_NS)
`endif

// ---- core/bc_exception_decode.v ----
`timescale 1ns/10ps
`include "bc_seq_regs.vh"
module bc_exception_decode (
  input wire [3:0] event_code, // exception class
  input wire [15:0] rt_status, // responding status word
  input wire [15:0] ctrl_word, // message control word
  input wire [8:0] cfg, // configuration bits
  output reg [15:0] set_bits, // block status bits to set
  output reg do_retry, // automatic retry wanted
  output reg keep_start_status, // leave status from start
  output reg terminate, // frame ends
  output reg skip_data, // stop storing data words
  output reg [4:0] irq_bits // interrupt requests, less retry and end of frame
);
  wire expanded = cfg[`CFG_ENHANCED] & cfg[`CFG_EXPANDED];
  wire me_masked = expanded & ctrl_word[`CW_ME_MASK];
  wire [10:0] unmasked = rt_status[10:0] & ~ctrl_word[10:0];
  wire ss_retry = cfg[`CFG_SS_RETRY];
  always @* begin
    set_bits = 16'h0000;
    do_retry = 1'b0;
    keep_start_status = 1'b0;
    terminate = 1'b0;
    skip_data = 1'b0;
    irq_bits = 5'h00;
    case (event_code)
      `EV_NO_RESP: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_TIMEOUT] = 1'b1;
        do_retry = 1'b1;
        irq_bits[`IRQ_FORMAT] = 1'b1;
      end
      `EV_WCE: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_WCE] = 1'b1;
        set_bits[`BS_FORMAT] = 1'b1;
        do_retry = 1'b1;
        irq_bits[`IRQ_FORMAT] = 1'b1;
      end
      `EV_SYNC: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_SYNC] = 1'b1;
        set_bits[`BS_FORMAT] = 1'b1;
        do_retry = 1'b1;
        irq_bits[`IRQ_FORMAT] = 1'b1;
      end
      `EV_INVALID: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_FORMAT] = 1'b1;
        set_bits[`BS_INVALID] = 1'b1;
        skip_data = 1'b1;
        do_retry = 1'b1;
        irq_bits[`IRQ_FORMAT] = 1'b1;
      end
      `EV_WRONG_ADDR: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_WRONG_ADDR] = 1'b1;
        set_bits[`BS_FORMAT] = 1'b1;
        do_retry = 1'b1;
        irq_bits[`IRQ_STATUS_SET] = 1'b1;
      end
      `EV_HANDSHAKE: begin
        keep_start_status = cfg[`CFG_TRANSPARENT];
        terminate = cfg[`CFG_TRANSPARENT];
        irq_bits[`IRQ_HANDSHAKE] = cfg[`CFG_TRANSPARENT];
      end
      `EV_NO_GAP: begin
        if (cfg[`CFG_ENHANCED] & cfg[`CFG_GAP_CHECK]) begin
          set_bits[`BS_ERROR] = 1'b1;
          set_bits[`BS_FORMAT] = 1'b1;
          set_bits[`BS_WRONG_ADDR] = 1'b1;
          do_retry = 1'b1;
          irq_bits[`IRQ_FORMAT] = 1'b1;
        end
      end
      `EV_LOOP_FAIL: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_LOOP_FAIL] = 1'b1;
        irq_bits[`IRQ_FORMAT] = 1'b1;
      end
      `EV_TX_TIMEOUT: begin
        keep_start_status = 1'b1;
        terminate = 1'b1;
        irq_bits[`IRQ_TX_TIMEOUT] = 1'b1;
      end
      `EV_STATUS_SET: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_SS] = 1'b1;
        if (!expanded) begin
          irq_bits[`IRQ_STATUS_SET] = 1'b1;
          do_retry = ss_retry;
        end else if (|unmasked) begin
          set_bits[`BS_SS_MASKED] = 1'b1;
          irq_bits[`IRQ_STATUS_SET] = 1'b1;
          do_retry = ss_retry;
        end
      end
      `EV_ME_NO_DATA: begin
        if (!cfg[`CFG_VALID_ME_ND]) begin
          set_bits[`BS_ERROR] = 1'b1;
          set_bits[`BS_SS] = 1'b1;
          set_bits[`BS_FORMAT] = 1'b1;
          set_bits[`BS_WCE] = 1'b1;
          set_bits[`BS_SS_MASKED] = ~me_masked;
          irq_bits[`IRQ_STATUS_SET] = ~me_masked;
          do_retry = 1'b1;
          irq_bits[`IRQ_FORMAT] = 1'b1;
        end
      end
      `EV_ME_DATA: begin
        set_bits[`BS_ERROR] = 1'b1;
        set_bits[`BS_SS] = 1'b1;
        set_bits[`BS_SS_MASKED] = ~me_masked;
        irq_bits[`IRQ_STATUS_SET] = ~me_masked;
        do_retry = ss_retry & ~me_masked;
      end
      default: begin
        set_bits = 16'h0000;
      end
    endcase
  end
endmodule

// ---- core/bc_message_sequencer.v ----
`timescale 1ns/10ps
`include "bc_seq_regs.vh"
module bc_message_sequencer (
  input wire clk, // 100 mhz clock
  input wire rst_n, // synchronous reset, active low
  input wire [7:0] paddr, // apb address
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  output reg mem_req, // shared ram request
  output reg mem_we, // shared ram write
  output reg [15:0] mem_addr, // shared ram address
  output reg [15:0] mem_wdata, // shared ram write data
  input wire mem_ack, // shared ram done
  input wire [15:0] mem_rdata, // shared ram read data
  input wire [15:0] time_tag, // time tag counter
  output reg [15:0] gap_time, // gap before message
  output reg [15:0] cmd_word, // first command word
  output reg [15:0] ctrl_word, // message control word
  output reg msg_go, // pulse: transmit message
  input wire msg_done, // pulse: message over
  input wire [3:0] event_code, // exception class with msg_done
  input wire [15:0] rt_status, // status word with msg_done
  input wire tx_active, // transmitter on
  input wire bus_idle, // bus quiet
  output reg store_inhibit, // do not store data words
  output reg [5:0] irq_pulse // one-cycle interrupt requests
);
  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 4'h0;
  localparam S_RD_SP = 4'h1;
  localparam S_RD_GAP = 4'h2;
  localparam S_RD_BP = 4'h3;
  localparam S_RD_CW = 4'h4;
  localparam S_RD_CMD = 4'h5;
  localparam S_WR_TT = 4'h6;
  localparam S_WR_BS = 4'h7;
  localparam S_RUN = 4'h8;
  localparam S_WAIT_IDLE = 4'h9;
  localparam S_RD_CNT = 4'ha;
  localparam S_E_TT = 4'hb;
  localparam S_E_BS = 4'hc;
  localparam S_E_CNT = 4'hd;
  localparam S_E_SP = 4'he;
  localparam S_RT_CNT = 4'hf;
  localparam [19:0] TX_LIMIT = `TX_TIMEOUT_CYC;

  reg [3:0] state;
  reg [15:0] stack_ptr;
  reg [15:0] blk_ptr;
  reg [15:0] msg_count;
  reg [15:0] blk_status;
  reg [15:0] start_status;
  reg last_msg;
  reg terminate_pend;
  reg retry_pend;
  reg [1:0] retry_cnt;
  reg [19:0] tx_cnt;
  reg tx_timeout_ev;
  reg retrying;
  reg [8:0] cfg;
  reg [1:0] max_retry;
  reg busy;
  reg [15:0] last_status;

  // ****************************************
  // apb slave
  // ****************************************
  wire wr_en = psel & penable & pwrite;
  wire start_wr = wr_en && paddr == `REG_CTRL && pwdata[`REG_CTRL_START];
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != `REG_CTRL) & (paddr != `REG_CFG) &
    (paddr != `REG_STATE) & (paddr != `REG_IRQ);
  reg [5:0] irq_seen;
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `REG_CTRL: rd_mux = {31'h0, busy};
      `REG_CFG: rd_mux = {22'h0, max_retry[1], max_retry[0], 8'h0} | {23'h0, cfg};
      `REG_STATE: rd_mux = {last_status, msg_count[7:0], 4'h0, state};
      `REG_IRQ: rd_mux = {26'h0, irq_seen};
      default: rd_mux = 32'h0;
    endcase
  end
  assign prdata = (psel & ~pwrite) ? rd_mux : 32'h0;

  always @(posedge clk) begin
    if (!rst_n) begin
      cfg <= 9'h000;
      max_retry <= 2'h1;
    end else if (wr_en && paddr == `REG_CFG) begin
      cfg <= pwdata[8:0];
      max_retry <= pwdata[`CFG_MAX_RETRY_LO+1:`CFG_MAX_RETRY_LO];
    end
  end

  // ****************************************
  // exception decode
  // ****************************************
  wire [15:0] ex_bits;
  wire ex_retry;
  wire ex_keep;
  wire ex_term;
  wire ex_skip;
  wire [4:0] ex_irq;
  wire [3:0] ev = tx_timeout_ev ? `EV_TX_TIMEOUT : event_code;
  bc_exception_decode u_decode (
    .event_code(ev),
    .rt_status(rt_status),
    .ctrl_word(ctrl_word),
    .cfg(cfg),
    .set_bits(ex_bits),
    .do_retry(ex_retry),
    .keep_start_status(ex_keep),
    .terminate(ex_term),
    .skip_data(ex_skip),
    .irq_bits(ex_irq)
  );
  wire retry_allowed = cfg[`CFG_RETRY_EN] & ctrl_word[`CW_RETRY] & (retry_cnt < max_retry);
  wire msg_end = (state == S_RUN) & (msg_done | tx_timeout_ev);

  // ****************************************
  // transmitter watchdog
  // ****************************************
  always @(posedge clk) begin
    if (!rst_n || state != S_RUN || !tx_active) begin
      tx_cnt <= 20'h00000;
      tx_timeout_ev <= 1'b0;
    end else if (tx_cnt == TX_LIMIT) begin
      tx_timeout_ev <= 1'b1;
    end else begin
      tx_cnt <= tx_cnt + 20'h00001;
    end
  end

  // ****************************************
  // ram transfer helper
  // ****************************************
  task issue;
    input we;
    input [15:0] addr;
    input [15:0] data;
    begin
      mem_req <= 1'b1;
      mem_we <= we;
      mem_addr <= addr;
      mem_wdata <= data;
    end
  endtask
  wire step = mem_req & mem_ack;

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      stack_ptr <= 16'h0000;
      blk_ptr <= 16'h0000;
      msg_count <= 16'h0000;
      blk_status <= 16'h0000;
      start_status <= 16'h0000;
      gap_time <= 16'h0000;
      cmd_word <= 16'h0000;
      ctrl_word <= 16'h0000;
      last_msg <= 1'b0;
      terminate_pend <= 1'b0;
      retry_pend <= 1'b0;
      retry_cnt <= 2'h0;
      retrying <= 1'b0;
      msg_go <= 1'b0;
      store_inhibit <= 1'b0;
      irq_pulse <= 6'h00;
      irq_seen <= 6'h00;
      busy <= 1'b0;
      last_status <= 16'h0000;
    end else begin
      msg_go <= 1'b0;
      irq_pulse <= 6'h00;
      if (wr_en && paddr == `REG_IRQ)
        irq_seen <= irq_seen & ~pwdata[5:0] | irq_pulse;
      else
        irq_seen <= irq_seen | irq_pulse;
      if (step)
        mem_req <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_wr) begin
            busy <= 1'b1;
            state <= S_RD_SP;
            issue(1'b0, `ADDR_STACK_PTR, 16'h0000);
          end
        end
        S_RD_SP: if (step) begin
          stack_ptr <= mem_rdata;
          retry_cnt <= 2'h0;
          state <= S_RD_GAP;
          issue(1'b0, mem_rdata + `OFS_GAP, 16'h0000);
        end
        S_RD_GAP: if (step) begin
          gap_time <= mem_rdata;
          state <= S_RD_BP;
          issue(1'b0, stack_ptr + `OFS_BLKPTR, 16'h0000);
        end
        S_RD_BP: if (step) begin
          blk_ptr <= mem_rdata;
          state <= S_RD_CW;
          issue(1'b0, mem_rdata + `OFS_CTRL, 16'h0000);
        end
        S_RD_CW: if (step) begin
          ctrl_word <= mem_rdata;
          state <= S_RD_CMD;
          issue(1'b0, blk_ptr + `OFS_CMD, 16'h0000);
        end
        S_RD_CMD: if (step) begin
          cmd_word <= mem_rdata;
          if (retrying) begin
            retrying <= 1'b0;
            msg_go <= 1'b1;
            state <= S_RUN;
          end else begin
            blk_status <= 16'h0000 | (16'h0001 << `BS_SOM);
            state <= S_WR_TT;
            issue(1'b1, stack_ptr + `OFS_TTAG, time_tag);
          end
        end
        S_WR_TT: if (step) begin
          state <= S_WR_BS;
          start_status <= blk_status;
          issue(1'b1, stack_ptr + `OFS_STATUS, blk_status);
        end
        S_WR_BS: if (step) begin
          msg_go <= 1'b1;
          state <= S_RUN;
        end
        S_RUN: if (msg_end) begin
          last_status <= rt_status;
          irq_pulse[4:0] <= ex_irq;
          store_inhibit <= ex_skip;
          terminate_pend <= ex_term;
          retry_pend <= ex_retry & retry_allowed & ~ex_term;
          if (ex_retry & retry_allowed & ~ex_term) begin
            retry_cnt <= retry_cnt + 2'h1;
            irq_pulse[`IRQ_RETRY] <= 1'b1;
          end
          if (ex_keep)
            blk_status <= start_status;
          else
            blk_status <= (blk_status | ex_bits) & ~(16'h0001 << `BS_SOM) |
              (16'h0001 << `BS_EOM);
          state <= S_WAIT_IDLE;
        end
        S_WAIT_IDLE: if (bus_idle) begin
          store_inhibit <= 1'b0;
          if (retry_pend) begin
            blk_status[`BS_RETRY_HI:`BS_RETRY_LO] <= retry_cnt;
            state <= S_RT_CNT;
            issue(1'b0, `ADDR_MSG_COUNT, 16'h0000);
          end else begin
            state <= S_RD_CNT;
            issue(1'b0, `ADDR_MSG_COUNT, 16'h0000);
          end
        end
        S_RT_CNT: if (step) begin
          msg_count <= mem_rdata;
          retrying <= 1'b1;
          retry_pend <= 1'b0;
          state <= S_RD_CW;
          issue(1'b0, blk_ptr + `OFS_CTRL, 16'h0000);
        end
        S_RD_CNT: if (step) begin
          if (mem_rdata == `COUNT_LAST) begin
            last_msg <= 1'b1;
            msg_count <= mem_rdata;
          end else begin
            last_msg <= 1'b0;
            msg_count <= mem_rdata + 16'h0001;
          end
          state <= S_E_TT;
          issue(1'b1, stack_ptr + `OFS_TTAG, time_tag);
        end
        S_E_TT: if (step) begin
          state <= S_E_BS;
          issue(1'b1, stack_ptr + `OFS_STATUS, blk_status);
        end
        S_E_BS: if (step) begin
          state <= S_E_CNT;
          issue(1'b1, `ADDR_MSG_COUNT, msg_count);
        end
        S_E_CNT: if (step) begin
          state <= S_E_SP;
          issue(1'b1, `ADDR_STACK_PTR, stack_ptr + `STACK_STEP);
        end
        S_E_SP: if (step) begin
          stack_ptr <= stack_ptr + `STACK_STEP;
          if (last_msg | terminate_pend) begin
            busy <= 1'b0;
            terminate_pend <= 1'b0;
            irq_pulse[`IRQ_EOF] <= 1'b1;
            state <= S_IDLE;
          end else begin
            state <= S_RD_SP;
            issue(1'b0, `ADDR_STACK_PTR, 16'h0000);
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- dv/sram.sv ----
`timescale 1ns/10ps
module sram (
  input wire logic clk, // clock
  input wire logic slow, // add wait states
  input wire logic mem_req, // request
  input wire logic mem_we, // write
  input wire logic [15:0] mem_addr, // word address
  input wire logic [15:0] mem_wdata, // write data
  output logic mem_ack, // done
  output logic [15:0] mem_rdata // read data
);
  // ****
  // shared ram
  // ****
  logic [15:0] mem [0:511];
  logic [16:0] acc_log [$];
  logic [1:0] waits;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    waits = 2'd0;
  end
  // data toggles when not answering, so stale data never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (waits != (slow ? 2'd3 : 2'd0))
        waits <= waits + 2'd1;
      else begin
        waits <= 2'd0;
        mem_ack <= 1'b1;
        acc_log.push_back({mem_we, mem_addr});
        if (mem_we)
          mem[mem_addr[8:0]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[8:0]];
      end
    end
  end
endmodule

// ---- dv/bc_seq_asserts.sv ----
`timescale 1ns/10ps
`include "bc_seq_regs.vh"
module bc_seq_asserts (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic mem_req, // ram request
  input wire logic mem_we, // ram write
  input wire logic [15:0] mem_addr, // ram address
  input wire logic [15:0] mem_wdata, // ram write data
  input wire logic mem_ack, // ram done
  input wire logic [15:0] mem_rdata, // ram read data
  input wire logic [15:0] time_tag, // time tag
  input wire logic bus_idle, // bus quiet
  input wire logic msg_go, // transmit pulse
  input wire logic store_inhibit // skip storing
);
  // ****
  // checks
  // ****
  logic [15:0] sp_q, cnt_q, nxt;
  logic nxt_v;
  wire acc = mem_req && mem_ack;
  wire rd_sp = acc && !mem_we && mem_addr == `ADDR_STACK_PTR;
  wire wr_cnt = acc && mem_we && mem_addr == `ADDR_MSG_COUNT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always @(posedge clk) begin
    if (!rst_n)
      nxt_v <= 1'b0;
    else if (acc)
      nxt_v <= rd_sp;
    if (acc)
      nxt <= mem_rdata + `OFS_GAP;
    if (rd_sp)
      sp_q <= mem_rdata;
    if (acc && !mem_we && mem_addr == `ADDR_MSG_COUNT)
      cnt_q <= mem_rdata;
  end
  property p_apb_ok;
    psel && penable && paddr <= `REG_IRQ && paddr[1:0] == 2'b00 |-> pready && !pslverr;
  endproperty
  a_apb_ok: assert property (p_apb_ok) else $error("mapped access refused");
  property p_apb_err;
    psel && penable && paddr > `REG_IRQ |-> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access accepted");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("ram request dropped");
  property p_gap_rd;
    acc && nxt_v |-> !mem_we && mem_addr == nxt;
  endproperty
  a_gap_rd: assert property (p_gap_rd) else $error("gap read misplaced");
  property p_sp_step;
    acc && mem_we && mem_addr == `ADDR_STACK_PTR |-> mem_wdata == sp_q + `STACK_STEP;
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("stack step wrong");
  property p_count;
    wr_cnt |-> mem_wdata == (cnt_q == `COUNT_LAST ? cnt_q : cnt_q + 16'h1);
  endproperty
  a_count: assert property (p_count) else $error("count update wrong");
  property p_ttag;
    acc && mem_we && mem_addr == sp_q + `OFS_TTAG |-> mem_wdata == time_tag;
  endproperty
  a_ttag: assert property (p_ttag) else $error("time tag wrong");
  property p_inhibit;
    store_inhibit && !bus_idle |-> !mem_req && !msg_go;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("busy bus not awaited");
  c_start: cover property (rd_sp);
  c_inhibit: cover property (store_inhibit);
  c_last: cover property (wr_cnt && mem_wdata == `COUNT_LAST);
endmodule
bind bc_message_sequencer bc_seq_asserts u_bc_seq_asserts (.*);

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "bc_seq_regs.vh"
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("BAD %0t %h %h", $time, g, e); \
  end \
end
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
  logic msg_go, msg_done, tx_active, bus_idle, store_inhibit, slow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, time_tag, gap_time, cmd_word, ctrl_word;
  logic [15:0] rt_status;
  logic [3:0] event_code;
  logic [5:0] irq_pulse;
  logic [16:0] lg [$];
  int fail_count, total_checks, go_cnt, go_seen;
  logic [16:0] exp_log [12] = '{17'h00100, 17'h00002, 17'h00003, 17'h00010, 17'h00011,
    17'h10001, 17'h10000, 17'h00101, 17'h10001, 17'h10000, 17'h10101, 17'h10100};
  bc_message_sequencer u_bc_message_sequencer (.*);
  sram u_sram (.*);
  // ****
  // tasks
  // ****
  task tally_and_finish;
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task setup(input [15:0] cnt, input [15:0] cw);
    u_sram.acc_log.delete();
    u_sram.mem[0] = 16'h0;
    u_sram.mem[2] = 16'h0320;
    u_sram.mem[3] = 16'h0010;
    u_sram.mem[4] = 16'h0;
    u_sram.mem[6] = 16'h03e8;
    u_sram.mem[7] = 16'h0010;
    u_sram.mem[9'h10] = cw;
    u_sram.mem[9'h11] = 16'h0824;
    u_sram.mem[9'h100] = 16'h0;
    u_sram.mem[9'h101] = cnt;
  endtask
  // plays the remote terminal side of one message
  task respond(input [3:0] ev);
    int n;
    n = 0;
    while (go_cnt == go_seen && n < 400) begin
      @(posedge clk);
      n++;
    end
    go_seen++;
    `CHK(go_cnt, go_seen)
    bus_idle <= 1'b0;
    repeat (3) @(posedge clk);
    msg_done <= 1'b1;
    event_code <= ev;
    @(posedge clk);
    msg_done <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({mem_req & (ev == `EV_INVALID), store_inhibit}, {1'b0, ev == `EV_INVALID})
    bus_idle <= 1'b1;
  endtask
  task wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 300) begin
      apb(1'b0, `REG_CTRL, 32'h0);
      n++;
    end
    `CHK(rd[0], 1'b0)
    `CHK(go_cnt, go_seen)
  endtask
  task t_frame;
    setup(16'hfffe, 16'h0);
    slow <= 1'b1;
    apb(1'b1, `REG_CFG, 32'h100);
    apb(1'b1, `REG_CTRL, 32'h1);
    respond(`EV_NONE);
    respond(`EV_NONE);
    wait_idle();
    for (int i = 0; i < 12; i++)
      `CHK(u_sram.acc_log[i], exp_log[i])
    `CHK(u_sram.mem[9'h100], 16'h0008)
    `CHK(u_sram.mem[9'h101], 16'hffff)
    `CHK({u_sram.mem[1], u_sram.mem[5]}, {time_tag, time_tag})
    `CHK({gap_time, cmd_word}, 32'h03e80824)
    slow <= 1'b0;
  endtask
  task t_case(input [3:0] ev, input [8:0] cfg, input [15:0] cw, input [15:0] bits,
      input rty, input [4:0] irq);
    setup(16'hffff, cw);
    apb(1'b1, `REG_CFG, {23'h0, cfg});
    apb(1'b1, `REG_IRQ, 32'h3f);
    apb(1'b1, `REG_CTRL, 32'h1);
    respond(ev);
    if (rty)
      respond(ev);
    wait_idle();
    lg = u_sram.acc_log;
    if (rty)
      `CHK({lg[7], lg[8], lg[9]}, {17'h00101, 17'h00010, 17'h00011})
    if (bits[14])
      `CHK(u_sram.mem[0], bits)
    else
      `CHK(u_sram.mem[0] & bits, bits)
    `CHK(u_sram.mem[0][2:1], {1'b0, rty})
    apb(1'b0, `REG_IRQ, 32'h0);
    `CHK(rd[5:0], {1'b1, irq})
  endtask
  // transmitter stuck on: watchdog ends the message and the frame
  task t_txto;
    setup(16'hfffe, 16'h0100);
    apb(1'b1, `REG_CFG, 32'h101);
    apb(1'b1, `REG_IRQ, 32'h3f);
    tx_active <= 1'b1;
    apb(1'b1, `REG_CTRL, 32'h1);
    while (go_cnt == go_seen)
      @(posedge clk);
    go_seen++;
    repeat (66850) @(posedge clk);
    tx_active <= 1'b0;
    wait_idle();
    `CHK(u_sram.mem[0], 16'h4000)
    `CHK({u_sram.mem[9'h101], u_sram.mem[9'h100]}, 32'hffff0004)
    apb(1'b0, `REG_IRQ, 32'h0);
    `CHK(rd[5:0], 6'h30)
  endtask
  task t_apb;
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, `REG_IRQ, 32'h3f);
    apb(1'b0, `REG_IRQ, 32'h0);
    `CHK(rd[5:0], 6'h0)
  endtask
  // ****
  // run
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (msg_go === 1'b1)
      go_cnt <= go_cnt + 1;
  initial begin
    #850000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, psel, penable, pwrite, msg_done, tx_active, slow} = 7'h0;
    bus_idle = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    time_tag = 16'h1234;
    rt_status = 16'h0410;
    event_code = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_frame();
    t_case(`EV_NO_RESP, 9'h101, 16'h0100, 16'h1400, 1'b1, 5'h05);
    t_case(`EV_WCE, 9'h101, 16'h0100, 16'h1048, 1'b1, 5'h05);
    t_case(`EV_SYNC, 9'h101, 16'h0100, 16'h1028, 1'b1, 5'h05);
    t_case(`EV_INVALID, 9'h101, 16'h0100, 16'h1018, 1'b1, 5'h05);
    t_case(`EV_WRONG_ADDR, 9'h103, 16'h0100, 16'h1088, 1'b1, 5'h06);
    t_case(`EV_HANDSHAKE, 9'h120, 16'h0100, 16'h4000, 1'b0, 5'h08);
    t_case(`EV_NO_GAP, 9'h115, 16'h0100, 16'h1088, 1'b1, 5'h05);
    t_case(`EV_LOOP_FAIL, 9'h101, 16'h0100, 16'h1200, 1'b0, 5'h01);
    t_case(`EV_STATUS_SET, 9'h103, 16'h0100, 16'h1100, 1'b1, 5'h06);
    t_case(`EV_STATUS_SET, 9'h10f, 16'h0100, 16'h1900, 1'b1, 5'h06);
    t_case(`EV_STATUS_SET, 9'h10f, 16'h07ff, 16'h1100, 1'b0, 5'h00);
    t_case(`EV_ME_NO_DATA, 9'h101, 16'h0100, 16'h1948, 1'b1, 5'h07);
    t_case(`EV_ME_DATA, 9'h103, 16'h0100, 16'h1900, 1'b1, 5'h06);
    t_apb();
    t_txto();
    tally_and_finish();
  end
endmodule
